/* File: rtl/iae_core.sv */
// Operation
// - Accepting a source clears that source's pending request flag.
// - Entry starts the cycle after the interrupted instruction completes.
// - Push bank, PC, status; set mask; load level; load vector; clear bank.
// - Handler address comes from the vector table below FFF hex.
// - Entry takes at least 15 clock cycles before the handler runs.
// - Ordinary sources load their level into the CPU priority level.
// - Reset sets the CPU priority level to 000.
// - Watchdog acceptance sets the CPU priority level to 111.
// - Zero-division and address-match leave the priority level unchanged.
// - Even stack pointer pushes PC and status as 16-bit words; odd pushes bytes; bank is always one byte.
// - Only bank, PC and status word are pushed by hardware.
// - Return pops bank, PC and status, restoring the priority level.
// - Nested requests need level above current level; lower ones stay pending.
// - Watchdog, zero-division, address-match are accepted regardless of mask or level.
// - Sense and polarity bits: 00 fall, 01 rise, 10 high, 11 low.
// - Pins are monitored continuously; unused sources should get level 0.
// - Accept only with mask 0, request 1, level above CPU level.
// - Detection time select: 00 seven, 01 four, 10 two cycles.
// - Level sense ignores the flag; request lasts only while level valid.
// - CPU priority level sits in status word bits 8 to 10.
`default_nettype none
module iae_core (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [iae_pkg::NPIN-1:0] ext_irq_pin,
	input wire logic wdt_req,
	input wire logic zdiv_req,
	input wire logic amatch_req,
	input wire logic opfetch,
	input wire logic instr_done,
	input wire logic [15:0] sp_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] bank_in,
	output logic push_valid,
	output var iae_pkg::iae_push_s push_beat,
	input wire logic push_ready,
	output logic vec_req,
	output logic [11:0] vec_addr,
	input wire logic [15:0] vec_data,
	input wire logic vec_ack,
	input wire logic rtn_valid,
	input wire logic [15:0] rtn_status,
	output logic entry_go,
	output logic [15:0] entry_pc,
	output logic [7:0] entry_bank,
	output logic [15:0] status_word,
	output logic ack_busy
);
	localparam int N = iae_pkg::NPIN;

	function automatic logic [2:0] det_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h1: det_cycles = iae_pkg::DET_CYC_MID;
			2'h2: det_cycles = iae_pkg::DET_CYC_FAST;
			default: det_cycles = iae_pkg::DET_CYC_SLOW; // Reserved code falls back to slowest
		endcase
	endfunction : det_cycles

	function automatic logic cfg_hit(input logic [7:0] a, input int i);
		cfg_hit = (a == 8'(iae_pkg::OFS_PINCFG0 + 8'(4 * i)));
	endfunction : cfg_hit

	iae_pkg::iae_state_e st_r, st_nxt;
	iae_pkg::iae_pincfg_s cfg_r [N];
	logic [N-1:0] pin_m_r, pin_s_r, pin_d_r;
	logic [N-1:0] req_now, acc_clr, snap_req_r;
	logic [2:0] snap_lvl_r [N];
	logic [1:0] detsel_r;
	logic [2:0] det_cnt_r;
	logic wdt_pend_r, zdiv_pend_r, amatch_pend_r;
	logic [3:0] src_r;
	logic [2:0] src_lvl_r;
	logic [15:0] sw_r, snap_pc_r, snap_sw_r;
	logic [7:0] snap_bank_r;
	logic sp_odd_r, half_r;
	logic [4:0] ack_cnt_r;
	logic push_valid_r, vec_req_r, entry_go_r;
	iae_pkg::iae_push_s beat_r, beat_nxt;
	logic beat_last;
	logic [11:0] vec_addr_r;
	logic [15:0] entry_pc_r;
	logic [7:0] entry_bank_r;
	logic [31:0] prdata_r;

	// Bus decode; zero wait states, so ready is tied high
	wire wr_acc = psel & penable & pwrite;
	wire setup = psel & ~penable;
	wire cfg_range = (paddr >= iae_pkg::OFS_PINCFG0) && (paddr <= iae_pkg::OFS_PINCFG_LAST) && (paddr[1:0] == 2'h0);
	wire addr_ok = cfg_range || paddr == iae_pkg::OFS_CTRL || paddr == iae_pkg::OFS_STATUS
		|| paddr == iae_pkg::OFS_PINLVL || paddr == iae_pkg::OFS_STATE;
	wire wr_ctrl = wr_acc && paddr == iae_pkg::OFS_CTRL;
	wire wr_sw = wr_acc && paddr == iae_pkg::OFS_STATUS;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// Two-stage pin synchroniser plus a history stage for edges
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_m_r <= '0;
			pin_s_r <= '0;
			pin_d_r <= '0;
		end else begin
			pin_m_r <= ext_irq_pin;
			pin_s_r <= pin_m_r;
			pin_d_r <= pin_s_r;
		end
	end

	// Per-pin sense logic and request flag; a new edge beats a clear
	for (genvar i = 0; i < N; i++) begin : g_pin
		wire rise = pin_s_r[i] & ~pin_d_r[i];
		wire fall = ~pin_s_r[i] & pin_d_r[i];
		wire edge_hit = ~cfg_r[i].sense & (cfg_r[i].pol ? rise : fall);
		wire level_ok = cfg_r[i].sense & (pin_s_r[i] == ~cfg_r[i].pol);
		assign req_now[i] = cfg_r[i].sense ? level_ok : cfg_r[i].req;
		iae_pkg::iae_pincfg_s cfg_nxt;
		always_comb begin
			cfg_nxt = cfg_r[i];
			if (wr_acc && cfg_hit(paddr, i))
				cfg_nxt = iae_pkg::iae_pincfg_s'(pwdata[5:0]);
			if (acc_clr[i])
				cfg_nxt.req = 1'b0;
			if (edge_hit)
				cfg_nxt.req = 1'b1;
		end
		always_ff @(posedge ref_clk) begin
			if (srst)
				cfg_r[i] <= '0;
			else
				cfg_r[i] <= cfg_nxt;
		end
	end

	// Arbitration over the latched snapshot; ties go to the higher pin
	logic [2:0] best_lvl;
	logic [2:0] best_idx;
	always_comb begin
		best_lvl = 3'h0;
		best_idx = 3'h0;
		for (int i = 0; i < N; i++) begin
			if (snap_req_r[i] && snap_lvl_r[i] != 3'h0 && snap_lvl_r[i] >= best_lvl) begin
				best_lvl = snap_lvl_r[i];
				best_idx = 3'(i);
			end
		end
	end

	wire [2:0] cpu_priority_level = sw_r[iae_pkg::SW_IPL_LSB +: 3];
	wire iflag = sw_r[iae_pkg::SW_IFLAG_BIT];
	wire det_end = (st_r == iae_pkg::ST_DET) && det_cnt_r == 3'h1;
	wire pin_win = det_end && ~iflag && best_lvl > cpu_priority_level;
	wire sp_any = wdt_pend_r | zdiv_pend_r | amatch_pend_r;
	wire sp_take = sp_any && (st_r == iae_pkg::ST_IDLE || st_r == iae_pkg::ST_DET);
	wire [3:0] sp_src = wdt_pend_r ? iae_pkg::SRC_WDT : (zdiv_pend_r ? iae_pkg::SRC_ZDIV : iae_pkg::SRC_AMATCH);
	wire pin_take = pin_win && ~sp_take;
	assign acc_clr = pin_take ? (N'(1) << best_idx) : '0;

	// Pending flags of the fixed-level sources; arrival beats acceptance
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wdt_pend_r <= 1'b0;
			zdiv_pend_r <= 1'b0;
			amatch_pend_r <= 1'b0;
		end else begin
			wdt_pend_r <= wdt_req | (wdt_pend_r & ~(sp_take && sp_src == iae_pkg::SRC_WDT));
			zdiv_pend_r <= zdiv_req | (zdiv_pend_r & ~(sp_take && sp_src == iae_pkg::SRC_ZDIV));
			amatch_pend_r <= amatch_req | (amatch_pend_r & ~(sp_take && sp_src == iae_pkg::SRC_AMATCH));
		end
	end

	// Stack beat selection: byte pushes go high byte first
	always_comb begin
		beat_nxt = '0;
		beat_last = 1'b1;
		unique case (1'b1)
			st_r == iae_pkg::ST_BANK:
				beat_nxt.data = {8'h00, snap_bank_r};
			st_r == iae_pkg::ST_PC: begin
				beat_nxt.wide = ~sp_odd_r;
				beat_nxt.data = ~sp_odd_r ? snap_pc_r : {8'h00, half_r ? snap_pc_r[7:0] : snap_pc_r[15:8]};
				beat_last = ~sp_odd_r | half_r;
			end
			st_r == iae_pkg::ST_PS: begin
				beat_nxt.wide = ~sp_odd_r;
				beat_nxt.data = ~sp_odd_r ? snap_sw_r : {8'h00, half_r ? snap_sw_r[7:0] : snap_sw_r[15:8]};
				beat_last = ~sp_odd_r | half_r;
			end
			default: beat_nxt = '0;
		endcase
	end

	wire beat_done = push_valid_r & push_ready;

	// Entry sequencer: bank, PC, status, mask, vector, then pad to minimum
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			iae_pkg::ST_IDLE:
				if (sp_take)
					st_nxt = iae_pkg::ST_WAIT;
				else if (opfetch)
					st_nxt = iae_pkg::ST_DET;
			iae_pkg::ST_DET:
				if (sp_take || pin_take)
					st_nxt = iae_pkg::ST_WAIT;
				else if (det_end)
					st_nxt = iae_pkg::ST_IDLE;
			iae_pkg::ST_WAIT:
				if (instr_done)
					st_nxt = iae_pkg::ST_BANK;
			iae_pkg::ST_BANK:
				if (beat_done)
					st_nxt = iae_pkg::ST_PC;
			iae_pkg::ST_PC:
				if (beat_done && beat_last)
					st_nxt = iae_pkg::ST_PS;
			iae_pkg::ST_PS:
				if (beat_done && beat_last)
					st_nxt = iae_pkg::ST_MASK;
			iae_pkg::ST_MASK:
				st_nxt = iae_pkg::ST_VEC;
			iae_pkg::ST_VEC:
				if (vec_ack)
					st_nxt = iae_pkg::ST_FILL;
			iae_pkg::ST_FILL:
				if (ack_cnt_r >= iae_pkg::ACK_MIN_CYC - 5'h1)
					st_nxt = iae_pkg::ST_IDLE;
			default: st_nxt = iae_pkg::ST_IDLE;
		endcase
	end

	// Sequencer state, detection timer and acceptance capture
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= iae_pkg::ST_IDLE;
			det_cnt_r <= '0;
			snap_req_r <= '0;
			src_r <= '0;
			src_lvl_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (st_r == iae_pkg::ST_IDLE && opfetch) begin
				det_cnt_r <= det_cycles(detsel_r);
				snap_req_r <= req_now; // Frozen so late changes wait for the next fetch
			end else if (st_r == iae_pkg::ST_DET) begin
				det_cnt_r <= det_cnt_r - 3'h1;
			end
			if (sp_take)
				src_r <= sp_src;
			else if (pin_take) begin
				src_r <= {1'b0, best_idx};
				src_lvl_r <= best_lvl;
			end
		end
	end

	for (genvar i = 0; i < N; i++) begin : g_snap
		always_ff @(posedge ref_clk) begin
			if (srst)
				snap_lvl_r[i] <= '0;
			else if (st_r == iae_pkg::ST_IDLE && opfetch)
				snap_lvl_r[i] <= cfg_r[i].lvl;
		end
	end

	// Context capture, stack beats, vector fetch and handler launch
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			snap_pc_r <= '0;
			snap_sw_r <= '0;
			snap_bank_r <= '0;
			sp_odd_r <= 1'b0;
			half_r <= 1'b0;
			ack_cnt_r <= '0;
			push_valid_r <= 1'b0;
			beat_r <= '0;
			vec_req_r <= 1'b0;
			vec_addr_r <= '0;
			entry_go_r <= 1'b0;
			entry_pc_r <= '0;
			entry_bank_r <= '0;
		end else begin
			entry_go_r <= 1'b0;
			ack_cnt_r <= ack_cnt_r + 5'h1;
			if (st_r == iae_pkg::ST_WAIT && instr_done) begin
				snap_pc_r <= pc_in;
				snap_bank_r <= bank_in;
				snap_sw_r <= sw_r;
				sp_odd_r <= sp_in[0];
				half_r <= 1'b0;
				ack_cnt_r <= '0;
			end
			if (beat_done) begin
				push_valid_r <= 1'b0;
				half_r <= ~beat_last;
			end else if (!push_valid_r && (st_r == iae_pkg::ST_BANK || st_r == iae_pkg::ST_PC
				|| st_r == iae_pkg::ST_PS)) begin
				push_valid_r <= 1'b1;
				beat_r <= beat_nxt;
			end
			if (st_r == iae_pkg::ST_MASK) begin
				vec_req_r <= 1'b1;
				vec_addr_r <= iae_pkg::VEC_TOP - {7'h00, src_r, 1'b0};
			end
			if (st_r == iae_pkg::ST_VEC && vec_ack) begin
				vec_req_r <= 1'b0;
				entry_pc_r <= vec_data;
			end
			if (st_r == iae_pkg::ST_FILL && st_nxt == iae_pkg::ST_IDLE) begin
				entry_go_r <= 1'b1;
				entry_bank_r <= iae_pkg::BANK_ENTRY;
			end
		end
	end

	// Status word: entry wins over a return, a return over a bus write
	logic [2:0] ipl_entry;
	always_comb begin
		if (src_r == iae_pkg::SRC_WDT)
			ipl_entry = iae_pkg::IPL_WDT;
		else if (src_r == iae_pkg::SRC_ZDIV || src_r == iae_pkg::SRC_AMATCH)
			ipl_entry = cpu_priority_level;
		else
			ipl_entry = src_lvl_r;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sw_r <= iae_pkg::SW_RST;
			detsel_r <= iae_pkg::DETSEL_RST;
		end else begin
			if (st_r == iae_pkg::ST_MASK) begin
				sw_r[iae_pkg::SW_IFLAG_BIT] <= 1'b1;
				sw_r[iae_pkg::SW_IPL_LSB +: 3] <= ipl_entry;
			end else if (rtn_valid)
				sw_r <= rtn_status;
			else if (wr_sw)
				sw_r <= pwdata[15:0];
			if (wr_ctrl)
				detsel_r <= pwdata[iae_pkg::CTRL_DET_LSB +: 2];
		end
	end

	// Read data is captured in the setup cycle and stands through access
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (paddr == iae_pkg::OFS_CTRL)
			rd_mux = {26'h0, detsel_r, 4'h0};
		else if (paddr == iae_pkg::OFS_STATUS)
			rd_mux = {16'h0000, sw_r};
		else if (paddr == iae_pkg::OFS_PINLVL)
			rd_mux = {24'h00_0000, pin_s_r};
		else if (paddr == iae_pkg::OFS_STATE)
			rd_mux = {23'h00_0000, st_r};
		for (int i = 0; i < N; i++)
			if (cfg_hit(paddr, i))
				rd_mux = {26'h0, cfg_r[i]};
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			prdata_r <= '0;
		else if (setup && !pwrite)
			prdata_r <= rd_mux;
	end

	assign prdata = prdata_r;
	assign push_valid = push_valid_r;
	assign push_beat = beat_r;
	assign vec_req = vec_req_r;
	assign vec_addr = vec_addr_r;
	assign entry_go = entry_go_r;
	assign entry_pc = entry_pc_r;
	assign entry_bank = entry_bank_r;
	assign status_word = sw_r;
	assign ack_busy = ~(st_r == iae_pkg::ST_IDLE || st_r == iae_pkg::ST_DET);
endmodule : iae_core
`default_nettype wire

/* File: rtl/iae_pkg.sv */
`default_nettype none
package iae_pkg;
	// Source count and register map
	localparam int NPIN = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PINCFG0 = 8'h08;
	localparam logic [7:0] OFS_PINCFG_LAST = 8'h24;
	localparam logic [7:0] OFS_PINLVL = 8'h28;
	localparam logic [7:0] OFS_STATE = 8'h2c;
	// Field positions
	localparam int CTRL_DET_LSB = 4;
	localparam int SW_IFLAG_BIT = 6;
	localparam int SW_IPL_LSB = 8;
	// Values after reset: mask flag set, priority level 0
	localparam logic [15:0] SW_RST = 16'h0040;
	localparam logic [1:0] DETSEL_RST = 2'h0;
	localparam logic [2:0] IPL_RST = 3'h0;
	localparam logic [2:0] IPL_WDT = 3'h7;
	localparam logic [7:0] BANK_ENTRY = 8'h00;
	// Cycle counts
	localparam logic [2:0] DET_CYC_SLOW = 3'h7;
	localparam logic [2:0] DET_CYC_MID = 3'h4;
	localparam logic [2:0] DET_CYC_FAST = 3'h2;
	localparam logic [4:0] ACK_MIN_CYC = 5'h0f;
	// Source identities and vector table top
	localparam logic [3:0] SRC_WDT = 4'h8;
	localparam logic [3:0] SRC_ZDIV = 4'h9;
	localparam logic [3:0] SRC_AMATCH = 4'ha;
	localparam logic [11:0] VEC_TOP = 12'hffe;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_DET = 9'h002,
		ST_WAIT = 9'h004,
		ST_BANK = 9'h008,
		ST_PC = 9'h010,
		ST_PS = 9'h020,
		ST_MASK = 9'h040,
		ST_VEC = 9'h080,
		ST_FILL = 9'h100
	} iae_state_e;

	// Per-pin configuration, laid out as it reads on the bus
	typedef struct packed {
		logic sense;
		logic pol;
		logic req;
		logic [2:0] lvl;
	} iae_pincfg_s;

	// One stack beat: 16-bit word or low byte only
	typedef struct packed {
		logic [15:0] data;
		logic wide;
	} iae_push_s;
endpackage : iae_pkg
`default_nettype wire

/* File: verif/iae_cpu_model.sv */
`default_nettype none
module iae_cpu_model (
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic push_valid,
	output logic push_ready,
	input wire logic vec_req,
	input wire logic [11:0] vec_addr,
	output logic [15:0] vec_data,
	output logic vec_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tick_r = 1'b0;
	// Slow mode answers every other cycle to stretch entry
	always @(posedge ref_clk)
		tick_r <= ~tick_r;
	// Answers follow the registered requests
	assign push_ready = push_valid & (~slow | tick_r);
	assign vec_ack = vec_req & (~slow | tick_r);
	// Inverted outside the answer cycle, so an early sample is caught
	assign vec_data = vec_ack ? {4'h1, vec_addr} : ~{4'h1, vec_addr};
endmodule : iae_cpu_model
`default_nettype wire

/* File: verif/iae_core_props.sv */
`default_nettype none
module iae_core_props (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic push_valid,
	input wire iae_pkg::iae_push_s push_beat,
	input wire logic push_ready,
	input wire logic vec_req,
	input wire logic [11:0] vec_addr,
	input wire logic [15:0] vec_data,
	input wire logic vec_ack,
	input wire logic rtn_valid,
	input wire logic [15:0] rtn_status,
	input wire logic entry_go,
	input wire logic [15:0] entry_pc,
	input wire logic [7:0] entry_bank,
	input wire logic [15:0] status_word,
	input wire logic ack_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic [15:0] vec_r;
	logic [7:0] busy_r;
	// Vector word taken, and cycles spent busy; the count saturates
	always_ff @(posedge ref_clk) begin
		if (vec_req && vec_ack)
			vec_r <= vec_data;
		busy_r <= (srst || !ack_busy) ? 8'h00 : busy_r + {7'h00, busy_r != 8'hff};
	end
	chk_rst_level: assert property (disable iff (1'b0) srst |=> status_word == 16'h0040)
		else $error("reset status wrong");
	chk_entry_bank: assert property (entry_go |-> entry_bank == 8'h00 && status_word[6])
		else $error("entry bank or mask wrong");
	chk_entry_vector: assert property (entry_go |-> entry_pc == vec_r)
		else $error("entry address not the vector");
	chk_entry_length: assert property (entry_go |-> busy_r >= 8'h0e)
		else $error("entry too short");
	chk_wdt_level: assert property (vec_req && vec_addr == 12'hfee |-> status_word[10:8] == 3'h7)
		else $error("watchdog level wrong");
	chk_zdiv_level: assert property (vec_req && vec_addr == 12'hfec |-> $stable(status_word[10:8]))
		else $error("zero-division level changed");
	chk_push_hold: assert property (push_valid && !push_ready |=> push_valid && $stable(push_beat))
		else $error("push beat dropped");
	chk_vec_hold: assert property (vec_req && !vec_ack |=> vec_req && vec_addr == $past(vec_addr))
		else $error("vector request dropped");
	chk_rtn_restore: assert property (rtn_valid && !ack_busy |=> status_word == $past(rtn_status))
		else $error("return did not restore status");
	chk_go_pulse: assert property (entry_go |=> !entry_go)
		else $error("entry pulse too long");
	cov_entry: cover property (entry_go);
	cov_wdt: cover property (vec_req && vec_addr == 12'hfee);
	cov_stall: cover property (push_valid && !push_ready);
endmodule : iae_core_props
`default_nettype wire

/* File: verif/iae_core_test.sv */
`default_nettype none
module iae_core_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, perr;
	logic [7:0] paddr = 8'h00, bank_in = 8'h00, entry_bank, ext_irq_pin = 8'h09;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, push_valid, push_ready, vec_req, vec_ack, entry_go, ack_busy;
	logic wdt_req = 1'b0, zdiv_req = 1'b0, amatch_req = 1'b0, opfetch = 1'b0, instr_done = 1'b0, rtn_valid = 1'b0;
	logic [15:0] sp_in = 16'h0000, pc_in = 16'h0000, rtn_status = 16'h0000, vec_data, entry_pc, status_word;
	logic [11:0] vec_addr;
	iae_pkg::iae_push_s push_beat;
	iae_pkg::iae_push_s beats[$];
	int err_count = 0, total_checks = 0, seed = 70, n;
	int det_tab[4] = '{7, 4, 2, 7};
	iae_core dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_irq_pin, .wdt_req, .zdiv_req, .amatch_req, .opfetch, .instr_done, .sp_in, .pc_in, .bank_in,
		.push_valid, .push_beat, .push_ready, .vec_req, .vec_addr, .vec_data, .vec_ack, .rtn_valid,
		.rtn_status, .entry_go, .entry_pc, .entry_bank, .status_word, .ack_busy);
	iae_cpu_model cpu (.ref_clk, .slow, .push_valid, .push_ready, .vec_req, .vec_addr, .vec_data, .vec_ack);
	always #25 ref_clk = ~ref_clk;
	// Record every stack beat the core accepts
	always @(posedge ref_clk)
		if (push_valid && push_ready)
			beats.push_back(push_beat);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Byte beats only carry the low byte, so the upper one is masked off
	function automatic logic [16:0] beat_exp(input logic odd, input logic [15:0] v);
		return odd ? {8'h00, v[15:8], 1'b0} : {v, 1'b1};
	endfunction : beat_exp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Wait for the answer however long it takes; only the watchdog ends a hang
		do @(posedge ref_clk); while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic take(input int det, input logic [15:0] sp, input logic [2:0] lvl, input logic [11:0] va,
			input logic [15:0] ps);
		logic [15:0] pc;
		logic [7:0] bk;
		pc = 16'($random(seed));
		bk = 8'($random(seed));
		beats.delete();
		opfetch <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			opfetch <= 1'b0;
			n++;
			@(negedge ref_clk);
		end while (ack_busy !== 1'b1 && n < 40);
		if (det > 0)
			chk(32'(n >= det && n <= det + 1), 32'h1);
		@(posedge ref_clk);
		instr_done <= 1'b1;
		sp_in <= sp;
		pc_in <= pc;
		bank_in <= bk;
		@(posedge ref_clk);
		instr_done <= 1'b0;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			if (n <= 2)
				chk(32'(push_valid), 32'(n == 2));
		end while (entry_go !== 1'b1 && n < 200);
		chk(32'(entry_go), 32'h1);
		chk(32'(n >= 15), 32'h1);
		chk({entry_bank, entry_pc}, {12'h001, va});
		chk(status_word, {5'h00, lvl, 8'h40});
		chk(beats.size(), sp[0] ? 5 : 3);
		chk({beats[0].data[7:0], beats[0].wide}, {bk, 1'b0});
		chk(beats[1] & (sp[0] ? 17'h001ff : 17'h1ffff), beat_exp(sp[0], pc));
		chk(beats[sp[0] ? 3 : 2] & (sp[0] ? 17'h001ff : 17'h1ffff), beat_exp(sp[0], ps));
		// Odd stack: the low bytes follow the high ones
		if (sp[0])
			chk({beats[2].data[7:0], beats[4].data[7:0]}, {pc[7:0], ps[7:0]});
		@(posedge ref_clk);
	endtask : take
	task automatic rtn;
		rtn_valid <= 1'b1;
		@(posedge ref_clk);
		rtn_valid <= 1'b0;
		@(negedge ref_clk);
		chk(status_word, 32'h0);
		@(posedge ref_clk);
	endtask : rtn
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// Main sequence: reset, one source per sense mode, nesting
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		apb(1'b0, iae_pkg::OFS_STATUS, 32'h0);
		chk(q, 32'h0000_0040);
		apb(1'b0, 8'h30, 32'h0);
		chk(q | {31'h0, perr}, 32'h1);
		apb(1'b1, iae_pkg::OFS_STATUS, 32'h0);
		ext_irq_pin[7:4] <= 4'($random(seed));
		// Pin k gets sense and polarity k and level k+1; pins 4 to 7 stay at level 0
		for (int k = 0; k < 4; k++)
			apb(1'b1, iae_pkg::OFS_PINCFG0 + 8'(4 * k), 32'(17 * k + 1));
		apb(1'b0, iae_pkg::OFS_PINLVL, 32'h0);
		chk(q, {24'h00_0000, ext_irq_pin});
		$display("setup done");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, iae_pkg::OFS_CTRL, 32'(k) << 4);
			ext_irq_pin[k] <= ~ext_irq_pin[k];
			repeat (4) @(posedge ref_clk);
			take(det_tab[k], {15'($random(seed)), k[0]}, 3'(k + 1), 12'hffe - 12'(2 * k), 16'h0000);
			if (k == 3) begin
				zdiv_req <= 1'b1;
				@(posedge ref_clk);
				zdiv_req <= 1'b0;
				take(0, 16'h1235, 3'h4, 12'hfec, 16'h0440);
				slow <= 1'b1;
				wdt_req <= 1'b1;
				@(posedge ref_clk);
				wdt_req <= 1'b0;
				take(0, 16'h2468, 3'h7, 12'hfee, 16'h0440);
				slow <= 1'b0;
				amatch_req <= 1'b1;
				@(posedge ref_clk);
				amatch_req <= 1'b0;
				take(0, 16'h1357, 3'h7, 12'hfea, 16'h0740);
			end
			ext_irq_pin[k] <= ~ext_irq_pin[k];
			apb(1'b0, iae_pkg::OFS_PINCFG0 + 8'(4 * k), 32'h0);
			if (k < 2)
				chk(32'(q[3]), 32'h0);
			rtn();
			$display("source %0d done", k);
		end
		// A level 1 edge must wait while the level is 3
		apb(1'b1, iae_pkg::OFS_STATUS, 32'h0000_0300);
		ext_irq_pin[0] <= 1'b0;
		repeat (4) @(posedge ref_clk);
		opfetch <= 1'b1;
		@(posedge ref_clk);
		opfetch <= 1'b0;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(ack_busy), 32'h0);
		@(posedge ref_clk);
		apb(1'b0, iae_pkg::OFS_PINCFG0, 32'h0);
		chk(32'(q[3]), 32'h1);
		apb(1'b0, iae_pkg::OFS_STATE, 32'h0);
		chk(q, 32'h1);
		apb(1'b1, iae_pkg::OFS_STATUS, 32'h0);
		take(7, 16'h0100, 3'h1, 12'hffe, 16'h0000);
		ext_irq_pin[0] <= 1'b1;
		rtn();
		$display("nesting done");
		end_sim();
	end
	// Watchdog on a hang, far beyond the expected run
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		end_sim();
	end
endmodule : iae_core_test
bind iae_core iae_core_props chk_i (.ref_clk, .srst, .push_valid, .push_beat, .push_ready, .vec_req, .vec_addr,
	.vec_data, .vec_ack, .rtn_valid, .rtn_status, .entry_go, .entry_pc, .entry_bank, .status_word, .ack_busy);
`default_nettype wire
